/* File: common/dhs_defs.svh */
// Constants of the dual hardware stack controller: register addresses,
// field positions, reset values and fixed geometry.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef DHS_DEFS_SVH
`define DHS_DEFS_SVH

// Register addresses on the processor's internal register port.
`define DHS_ADDR_SPR   5'h09
`define DHS_ADDR_SUR   5'h0a
`define DHS_ADDR_SVR   5'h0b
`define DHS_ADDR_IBC   5'h10

// Reset values.
`define DHS_SPR_RST    16'h0000
`define DHS_SUR_RST    16'h0303
`define DHS_SVR_RST    16'hffff

// Bits of the underflow limit register that hold state; the rest read 0.
`define DHS_SUR_MASK   16'hfbfb

// Field positions inside the pointer, limit and mode registers.
`define DHS_P_LSB      0
`define DHS_R_LSB      8
`define DHS_START_BIT  0
`define DHS_SIZE_BIT   1
`define DHS_ULIM_LSB   3

// Error flag positions in the interrupt base/control word.
`define DHS_IBC_FATAL  0
`define DHS_IBC_PUDF   1
`define DHS_IBC_RUDF   2
`define DHS_IBC_POVF   3
`define DHS_IBC_ROVF   4

// Stack geometry.
`define DHS_DEPTH      64
`define DHS_PTR_W      6

`endif

/* File: common/dhs_pkg.sv */
// Types shared by the dual hardware stack controller modules.
// Assumes dhs_defs.svh is reachable on the include path.
`include "dhs_defs.svh"

package dhs_pkg;
  // Stack memory address and pointer field.
  typedef logic [`DHS_PTR_W-1:0] dhs_ptr_t;
  // One 16-bit register word.
  typedef logic [15:0]           dhs_word_t;
  // Register port address.
  typedef logic [4:0]            dhs_addr_t;
endpackage

/* File: verilog/dhs_stack_ram.sv */
// Stack memory of one stack: one write port and one registered read port.
// Assumes the caller never reads and writes in the same cycle.
`timescale 1ns/1ns

module dhs_stack_ram #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64
) (
  input  wire logic                     clk_i,
  input  wire logic                     ce_i,
  input  wire logic                     we_i,
  input  wire logic                     re_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  output logic      [WIDTH-1:0]         rdata_o
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rdata_ff;

  // Refuse geometries the pointer logic cannot address.
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("dhs_stack_ram: unsupported geometry");
  end

  // Memory array and read register; contents are undefined after reset.
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    if (ce_i && re_i) begin
      rdata_ff <= mem_ff[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;

endmodule

/* File: verilog/dhs_limits.sv */
// Derives overflow, underflow and fatal addresses of one stack from its
// pointer bank bit, overflow limit and underflow/mode field.
// Assumes the fields are stable registers on the same clock.
`timescale 1ns/1ns
`include "dhs_defs.svh"

module dhs_limits
  import dhs_pkg::*;
(
  input  wire logic          bank_i,
  input  wire dhs_pkg::dhs_ptr_t ovf_lim_i,
  input  wire logic [7:0]    mode_i,
  output dhs_pkg::dhs_ptr_t  ovf_addr_o,
  output dhs_pkg::dhs_ptr_t  udf_addr_o,
  output dhs_pkg::dhs_ptr_t  fat_addr_o
);

  logic wide;
  logic start;
  logic mid32;
  logic mid64;

  // Middle start only applies when the limit sits in the upper half.
  assign wide  = mode_i[`DHS_SIZE_BIT];
  assign start = mode_i[`DHS_START_BIT];
  assign mid32 = ovf_lim_i[4] & ~start;
  assign mid64 = ovf_lim_i[5] & ~start;

  // Address decode per stack size and start flag.
  always_comb begin
    if (wide) begin
      ovf_addr_o = {ovf_lim_i[5] & start, ovf_lim_i[4:0]};
      udf_addr_o = {mid64, mode_i[7:3]};
      fat_addr_o = {~mid64, 5'h1f};
    end else begin
      ovf_addr_o = {bank_i, ovf_lim_i[4] & start, ovf_lim_i[3:0]};
      udf_addr_o = {bank_i, mid32, mode_i[6:3]};
      fat_addr_o = {bank_i, ~mid32, 4'hf};
    end
  end

endmodule

/* File: verilog/dhs_ctrl.sv */
// Dual hardware stack controller: parameter and return stacks with pointer,
// limit and mode registers, error flags and error interrupt requests.
// Assumes a core on the same clock that issues push and pop strobes and
// reads or writes the registers over a simple internal register port.
//
// Behaviour
// - Push writes memory at the pointer, then increments the pointer.
// - Pop reads memory one below the pointer, then decrements it.
// - After reset the first push on each stack lands at location 0.
// - Size bit 1 or 9: 0 gives 32-word substacks, 1 one 64-word stack.
// - In 32-word mode pointer bit 5 or 13 holds, lower five bits count.
// - Start flags, bits 0 and 8, steer only limits, never the pointer.
// - Start flag 1 or low overflow limit: bottom start; else middle start.
// - Overflow flags when a push writes the overflow limit address.
// - Underflow flags when a pop reads just below the underflow limit.
// - Fatal flags when push or pop touches the fatal address.
// - Fatal raises no request; both fatals OR into control bit 0.
// - Error flags read in control bits 0 to 4; writes ignored.
// - All error flags hold until the pointer register is written.
// - Stacks and substacks wrap circularly in both directions.
// - Overflow and underflow raise requests to the interrupt controller.
// - Pointer register: parameter in bits 0-5, return in 8-13.
// - Overflow limit register is write-only and resets to all ones.
// - Overflow flags at bits 3 and 4, underflow flags at bits 1 and 2.
// - Return memory 21 by 64, parameter memory 16 by 64.
`timescale 1ns/1ns
`include "dhs_defs.svh"

module dhs_ctrl
  import dhs_pkg::*;
#(
  parameter int PW    = 16,
  parameter int RW    = 21,
  parameter int DEPTH = `DHS_DEPTH
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire dhs_pkg::dhs_addr_t reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire dhs_pkg::dhs_word_t reg_wdata_i,
  output dhs_pkg::dhs_word_t     reg_rdata_o,
  input  wire logic              param_push_i,
  input  wire logic              param_pop_i,
  input  wire logic [PW-1:0]     param_wdata_i,
  output logic      [PW-1:0]     param_rdata_o,
  input  wire logic              return_push_i,
  input  wire logic              return_pop_i,
  input  wire logic [RW-1:0]     return_wdata_i,
  output logic      [RW-1:0]     return_rdata_o,
  output logic                   param_overflow_request_o,
  output logic                   return_overflow_request_o,
  output logic                   param_underflow_request_o,
  output logic                   return_underflow_request_o
);

  // Refuse configurations the six-bit pointer fields cannot serve.
  if (DEPTH != `DHS_DEPTH || PW < 1 || RW < 1) begin : g_bad
    $error("dhs_ctrl: depth must be 64 and widths positive");
  end

  // Next pointer value; the bank bit holds unless the stack is 64 words.
  function automatic dhs_ptr_t ptr_step(dhs_ptr_t p, logic wide, logic up);
    dhs_ptr_t s;
    s = up ? p + 6'h01 : p - 6'h01;
    return wide ? s : {p[5], s[4:0]};
  endfunction

  // Register state.
  dhs_word_t sur_ff;
  dhs_word_t nxt_sur;
  dhs_ptr_t  p_lim_ff;
  dhs_ptr_t  nxt_p_lim;
  dhs_ptr_t  r_lim_ff;
  dhs_ptr_t  nxt_r_lim;
  dhs_ptr_t  p_ptr_ff;
  dhs_ptr_t  nxt_p_ptr;
  dhs_ptr_t  r_ptr_ff;
  dhs_ptr_t  nxt_r_ptr;
  dhs_word_t rdata_ff;
  dhs_word_t nxt_rdata;

  // Error flags.
  logic p_ovf_ff;
  logic nxt_p_ovf;
  logic r_ovf_ff;
  logic nxt_r_ovf;
  logic p_udf_ff;
  logic nxt_p_udf;
  logic r_udf_ff;
  logic nxt_r_udf;
  logic p_fat_ff;
  logic nxt_p_fat;
  logic r_fat_ff;
  logic nxt_r_fat;

  // Decoded operations and derived addresses.
  logic     spr_wr;
  logic     p_push;
  logic     p_pop;
  logic     r_push;
  logic     r_pop;
  logic     p_wide;
  logic     r_wide;
  dhs_ptr_t p_raddr;
  dhs_ptr_t r_raddr;
  dhs_ptr_t p_ovf_addr;
  dhs_ptr_t p_udf_addr;
  dhs_ptr_t p_fat_addr;
  dhs_ptr_t r_ovf_addr;
  dhs_ptr_t r_udf_addr;
  dhs_ptr_t r_fat_addr;
  logic     p_ovf_hit;
  logic     p_udf_hit;
  logic     p_fat_hit;
  logic     r_ovf_hit;
  logic     r_udf_hit;
  logic     r_fat_hit;

  // Operation decode; a push takes precedence over a pop in the same cycle.
  assign spr_wr = reg_wr_i && reg_addr_i == `DHS_ADDR_SPR;
  assign p_push = param_push_i;
  assign p_pop  = param_pop_i && !param_push_i;
  assign r_push = return_push_i;
  assign r_pop  = return_pop_i && !return_push_i;
  assign p_wide = sur_ff[`DHS_SIZE_BIT];
  assign r_wide = sur_ff[`DHS_R_LSB + `DHS_SIZE_BIT];

  assign p_raddr = ptr_step(p_ptr_ff, p_wide, 1'b0);
  assign r_raddr = ptr_step(r_ptr_ff, r_wide, 1'b0);

  dhs_stack_ram #(
    .WIDTH (PW),
    .DEPTH (DEPTH)
  ) u_param_ram (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (p_push),
    .re_i    (p_pop),
    .waddr_i (p_ptr_ff),
    .raddr_i (p_raddr),
    .wdata_i (param_wdata_i),
    .rdata_o (param_rdata_o)
  );

  dhs_stack_ram #(
    .WIDTH (RW),
    .DEPTH (DEPTH)
  ) u_return_ram (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (r_push),
    .re_i    (r_pop),
    .waddr_i (r_ptr_ff),
    .raddr_i (r_raddr),
    .wdata_i (return_wdata_i),
    .rdata_o (return_rdata_o)
  );

  dhs_limits u_param_lim (
    .bank_i     (p_ptr_ff[5]),
    .ovf_lim_i  (p_lim_ff),
    .mode_i     (sur_ff[7:0]),
    .ovf_addr_o (p_ovf_addr),
    .udf_addr_o (p_udf_addr),
    .fat_addr_o (p_fat_addr)
  );

  dhs_limits u_return_lim (
    .bank_i     (r_ptr_ff[5]),
    .ovf_lim_i  (r_lim_ff),
    .mode_i     (sur_ff[15:8]),
    .ovf_addr_o (r_ovf_addr),
    .udf_addr_o (r_udf_addr),
    .fat_addr_o (r_fat_addr)
  );

  // Limit hits; an underflow is a read of the word just below the limit.
  always_comb begin
    p_ovf_hit = p_push && p_ptr_ff == p_ovf_addr;
    r_ovf_hit = r_push && r_ptr_ff == r_ovf_addr;
    p_udf_hit = p_pop && p_raddr == ptr_step(p_udf_addr, p_wide, 1'b0);
    r_udf_hit = r_pop && r_raddr == ptr_step(r_udf_addr, r_wide, 1'b0);
    p_fat_hit = (p_push && p_ptr_ff == p_fat_addr) || (p_pop && p_raddr == p_fat_addr);
    r_fat_hit = (r_push && r_ptr_ff == r_fat_addr) || (r_pop && r_raddr == r_fat_addr);
  end

  // Pointer next values; a pointer write wins over a core access.
  always_comb begin
    nxt_p_ptr = p_ptr_ff;
    nxt_r_ptr = r_ptr_ff;
    if (spr_wr) begin
      nxt_p_ptr = reg_wdata_i[`DHS_P_LSB +: `DHS_PTR_W];
      nxt_r_ptr = reg_wdata_i[`DHS_R_LSB +: `DHS_PTR_W];
    end else begin
      if (p_push) begin
        nxt_p_ptr = ptr_step(p_ptr_ff, p_wide, 1'b1);
      end else if (p_pop) begin
        nxt_p_ptr = p_raddr;
      end
      if (r_push) begin
        nxt_r_ptr = ptr_step(r_ptr_ff, r_wide, 1'b1);
      end else if (r_pop) begin
        nxt_r_ptr = r_raddr;
      end
    end
  end

  // Limit and mode register next values.
  always_comb begin
    nxt_sur   = sur_ff;
    nxt_p_lim = p_lim_ff;
    nxt_r_lim = r_lim_ff;
    if (reg_wr_i && reg_addr_i == `DHS_ADDR_SUR) begin
      nxt_sur = reg_wdata_i & `DHS_SUR_MASK;
    end
    if (reg_wr_i && reg_addr_i == `DHS_ADDR_SVR) begin
      nxt_p_lim = reg_wdata_i[`DHS_P_LSB +: `DHS_PTR_W];
      nxt_r_lim = reg_wdata_i[`DHS_R_LSB +: `DHS_PTR_W];
    end
  end

  // Error flags: a new hit in the clearing cycle still sets the flag.
  always_comb begin
    nxt_p_ovf = (p_ovf_ff && !spr_wr) || p_ovf_hit;
    nxt_r_ovf = (r_ovf_ff && !spr_wr) || r_ovf_hit;
    nxt_p_udf = (p_udf_ff && !spr_wr) || p_udf_hit;
    nxt_r_udf = (r_udf_ff && !spr_wr) || r_udf_hit;
    nxt_p_fat = (p_fat_ff && !spr_wr) || p_fat_hit;
    nxt_r_fat = (r_fat_ff && !spr_wr) || r_fat_hit;
  end

  // Register read data, returned one cycle after the read strobe.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `DHS_ADDR_SPR: nxt_rdata = {2'h0, r_ptr_ff, 2'h0, p_ptr_ff};
        `DHS_ADDR_SUR: nxt_rdata = sur_ff & `DHS_SUR_MASK;
        `DHS_ADDR_IBC: begin
          nxt_rdata = 16'h0000;
          nxt_rdata[`DHS_IBC_FATAL] = p_fat_ff | r_fat_ff;
          nxt_rdata[`DHS_IBC_PUDF]  = p_udf_ff;
          nxt_rdata[`DHS_IBC_RUDF]  = r_udf_ff;
          nxt_rdata[`DHS_IBC_POVF]  = p_ovf_ff;
          nxt_rdata[`DHS_IBC_ROVF]  = r_ovf_ff;
        end
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  // State registers; reset wins over the clock enable, otherwise clock enable low freezes everything.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_ptr_ff <= dhs_ptr_t'(`DHS_SPR_RST);
      r_ptr_ff <= dhs_ptr_t'(`DHS_SPR_RST >> `DHS_R_LSB);
      sur_ff   <= `DHS_SUR_RST;
      p_lim_ff <= dhs_ptr_t'(`DHS_SVR_RST);
      r_lim_ff <= dhs_ptr_t'(`DHS_SVR_RST >> `DHS_R_LSB);
      rdata_ff <= 16'h0000;
      p_ovf_ff <= 1'b0;
      r_ovf_ff <= 1'b0;
      p_udf_ff <= 1'b0;
      r_udf_ff <= 1'b0;
      p_fat_ff <= 1'b0;
      r_fat_ff <= 1'b0;
    end else if (ce_i) begin
      p_ptr_ff <= nxt_p_ptr;
      r_ptr_ff <= nxt_r_ptr;
      sur_ff   <= nxt_sur;
      p_lim_ff <= nxt_p_lim;
      r_lim_ff <= nxt_r_lim;
      rdata_ff <= nxt_rdata;
      p_ovf_ff <= nxt_p_ovf;
      r_ovf_ff <= nxt_r_ovf;
      p_udf_ff <= nxt_p_udf;
      r_udf_ff <= nxt_r_udf;
      p_fat_ff <= nxt_p_fat;
      r_fat_ff <= nxt_r_fat;
    end
  end

  assign reg_rdata_o = rdata_ff;

  assign param_overflow_request_o   = p_ovf_ff;
  assign return_overflow_request_o  = r_ovf_ff;
  assign param_underflow_request_o  = p_udf_ff;
  assign return_underflow_request_o = r_udf_ff;

endmodule

/* File: tb/dhs_ctrl_monitor.sv */
// Concurrent checks on the ports of the dual stack controller.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
`include "dhs_defs.svh"

module dhs_ctrl_monitor
  import dhs_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               ce_i,
  input wire dhs_pkg::dhs_addr_t reg_addr_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire dhs_pkg::dhs_word_t reg_rdata_o,
  input wire logic               param_push_i,
  input wire logic               param_pop_i,
  input wire logic               return_push_i,
  input wire logic               return_pop_i,
  input wire logic               param_overflow_request_o,
  input wire logic               return_overflow_request_o,
  input wire logic               param_underflow_request_o,
  input wire logic               return_underflow_request_o
);
  import dhs_pkg::*;
  logic       spr_wr;
  logic       stk;
  logic       rd_spr;
  logic       rd_svr;
  logic       rd_ibc;
  logic [3:0] req;

  // Qualified strobes and the request bundle seen by the checks.
  assign spr_wr = ce_i & reg_wr_i & (reg_addr_i == `DHS_ADDR_SPR);
  assign stk = param_push_i | param_pop_i | return_push_i | return_pop_i;
  assign rd_spr = ce_i & reg_rd_i & (reg_addr_i == `DHS_ADDR_SPR);
  assign rd_svr = ce_i & reg_rd_i & (reg_addr_i == `DHS_ADDR_SVR);
  assign rd_ibc = ce_i & reg_rd_i & (reg_addr_i == `DHS_ADDR_IBC);
  assign req = {param_overflow_request_o, return_overflow_request_o,
                param_underflow_request_o, return_underflow_request_o};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_clear_on_spr: assert property (
    spr_wr && !stk |=> req == 4'h0) else $error("request survives pointer write");
  a_req_holds: assert property (
    (|($past(req) & ~req)) |-> $past(spr_wr)) else $error("request fell without pointer write");
  a_povf_cause: assert property (
    $rose(param_overflow_request_o) |-> $past(param_push_i)) else $error("param overflow without push");
  a_rovf_cause: assert property (
    $rose(return_overflow_request_o) |-> $past(return_push_i)) else $error("return overflow without push");
  a_pudf_cause: assert property (
    $rose(param_underflow_request_o) |-> $past(param_pop_i) && !$past(param_push_i))
    else $error("param underflow without pop");
  a_rudf_cause: assert property (
    $rose(return_underflow_request_o) |-> $past(return_pop_i) && !$past(return_push_i))
    else $error("return underflow without pop");
  a_svr_reads_0: assert property (
    rd_svr |=> reg_rdata_o == 16'h0000) else $error("overflow limits readable");
  a_spr_reserved: assert property (
    rd_spr |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[15:14] == 2'h0) else $error("pointer reserved bits set");
  a_ibc_upper_0: assert property (
    rd_ibc |=> reg_rdata_o[15:5] == 11'h000) else $error("flag word upper bits set");

  // Main scenarios reached.
  c_povf: cover property ($rose(param_overflow_request_o));
  c_pudf: cover property ($rose(param_underflow_request_o));
  c_clear: cover property (spr_wr && req != 4'h0);
endmodule

bind dhs_ctrl dhs_ctrl_monitor dhs_ctrl_monitor_i (.clk_i, .rst_i, .ce_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .param_push_i, .param_pop_i, .return_push_i, .return_pop_i,
  .param_overflow_request_o, .return_overflow_request_o, .param_underflow_request_o,
  .return_underflow_request_o);

/* File: tb/dhs_core_model.sv */
// Model of the processor core that drives both stack ports.
// Assumes step is called just after a rising edge; each call spends one
// request cycle and one idle cycle.
`timescale 1ns/1ns

module dhs_core_model (
  input  wire logic        clk_i,
  output logic             param_push_o,
  output logic             param_pop_o,
  output logic [15:0]      param_wdata_o,
  output logic             return_push_o,
  output logic             return_pop_o,
  output logic [20:0]      return_wdata_o
);
  // Idle strobes from time zero.
  initial begin
    param_push_o = 1'b0;
    param_pop_o = 1'b0;
    param_wdata_o = 16'h0000;
    return_push_o = 1'b0;
    return_pop_o = 1'b0;
    return_wdata_o = 21'h000000;
  end

  // One request cycle and one idle cycle; unused data lines show the inverse of their last value.
  task automatic step(input logic pu, po, input logic [15:0] pd, input logic [20:0] rd);
    param_push_o = pu;
    param_pop_o = po;
    param_wdata_o = pu ? pd : ~param_wdata_o;
    return_push_o = pu;
    return_pop_o = po;
    return_wdata_o = pu ? rd : ~return_wdata_o;
    @(posedge clk_i);
    #1;
    // Strobes drop for one idle edge so a request is never repeated by accident.
    param_push_o = 1'b0;
    param_pop_o = 1'b0;
    return_push_o = 1'b0;
    return_pop_o = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
endmodule

/* File: tb/tb_dhs_ctrl.sv */
// Self-checking bench for the dual stack controller.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ns
`include "dhs_defs.svh"

module tb_dhs_ctrl;
  import dhs_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  dhs_addr_t   reg_addr_i;
  dhs_word_t   reg_wdata_i;
  dhs_word_t   reg_rdata_o;
  logic        pu, po, ru, ro, pov, rov, pud, rud;
  logic [15:0] pwd, prd;
  logic [20:0] rwd, rrd;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;

  dhs_ctrl dhs_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .param_push_i(pu), .param_pop_i(po), .param_wdata_i(pwd), .param_rdata_o(prd),
    .return_push_i(ru), .return_pop_i(ro), .return_wdata_i(rwd), .return_rdata_o(rrd),
    .param_overflow_request_o(pov), .return_overflow_request_o(rov),
    .param_underflow_request_o(pud), .return_underflow_request_o(rud));

  dhs_core_model dhs_core_model_i (.clk_i(clk_i), .param_push_o(pu), .param_pop_o(po),
    .param_wdata_o(pwd), .return_push_o(ru), .return_pop_o(ro), .return_wdata_o(rwd));

  // Clock of 10 ns period.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Prints the verdict and ends the run.
  task automatic results();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end

  // One register port cycle, held across one edge.
  task automatic bus(input logic w, r, input dhs_addr_t a, input dhs_word_t d);
    reg_wr_i = w;
    reg_rd_i = r;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input dhs_addr_t a, input dhs_word_t d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, 16'h0000);
  endtask

  task automatic chkw(input dhs_word_t got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkd(input logic [20:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  // Reads a register and compares it.
  task automatic rdc(input dhs_addr_t a, input dhs_word_t exp);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, a, 16'h0000);
    chkw(reg_rdata_o, exp);
  endtask

  // Both stacks move together; return data carries a fixed upper field.
  task automatic push(input logic [15:0] d);
    dhs_core_model_i.step(1'b1, 1'b0, d, {5'h15, d});
  endtask

  task automatic pop_chk(input logic [15:0] d);
    dhs_core_model_i.step(1'b0, 1'b1, 16'h0000, 21'h000000);
    dhs_core_model_i.step(1'b0, 1'b0, 16'h0000, 21'h000000);
    chkd({5'h00, prd}, {5'h00, d});
    chkd(rrd, {5'h15, d});
  endtask

  // Main sequence.
  initial begin
    ce_i = 1'b1;
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 16'h0000;
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    rdc(`DHS_ADDR_SPR, 16'h0000);
    rdc(`DHS_ADDR_SUR, 16'h0303);
    rdc(`DHS_ADDR_SVR, 16'h0000);
    rdc(5'h1f, 16'h0000);
    push(16'h1234);
    push(16'h5678);
    rdc(`DHS_ADDR_SPR, 16'h0202);
    pop_chk(16'h5678);
    pop_chk(16'h1234);
    rdc(`DHS_ADDR_SPR, 16'h0000);
    // Overflow and fatal at 63 with the reset limits, then wrap to 0.
    wr(`DHS_ADDR_SPR, 16'h3e3e);
    push(16'h00aa);
    rdc(`DHS_ADDR_IBC, 16'h0000);
    push(16'h00bb);
    rdc(`DHS_ADDR_IBC, 16'h0019);
    chkw({12'h000, pov, rov, pud, rud}, 16'h000c);
    wr(`DHS_ADDR_IBC, 16'h0000);
    rdc(`DHS_ADDR_IBC, 16'h0019);
    rdc(`DHS_ADDR_SPR, 16'h0000);
    wr(`DHS_ADDR_SPR, 16'h0000);
    rdc(`DHS_ADDR_IBC, 16'h0000);
    chkw({12'h000, pov, rov, pud, rud}, 16'h0000);
    // Pop from 0 wraps to 63 and underflows.
    pop_chk(16'h00bb);
    rdc(`DHS_ADDR_IBC, 16'h0007);
    chkw({12'h000, pov, rov, pud, rud}, 16'h0003);
    rdc(`DHS_ADDR_SPR, 16'h3f3f);
    // Middle start in 64-word mode moves the limits to 31 and 32.
    wr(`DHS_ADDR_SUR, 16'h0202);
    wr(`DHS_ADDR_SPR, 16'h1e1e);
    push(16'h0030);
    rdc(`DHS_ADDR_IBC, 16'h0000);
    push(16'h0031);
    rdc(`DHS_ADDR_IBC, 16'h0019);
    rdc(`DHS_ADDR_SPR, 16'h2020);
    wr(`DHS_ADDR_SPR, 16'h2020);
    pop_chk(16'h0031);
    rdc(`DHS_ADDR_IBC, 16'h0007);
    // Underflow limit 2 and overflow limit 5, fatal stays at 63.
    // limits leave a margin below the fatal address
    wr(`DHS_ADDR_SUR, 16'h1313);
    wr(`DHS_ADDR_SVR, 16'h0505);
    wr(`DHS_ADDR_SPR, 16'h0303);
    dhs_core_model_i.step(1'b0, 1'b1, 16'h0000, 21'h000000);
    rdc(`DHS_ADDR_IBC, 16'h0000);
    dhs_core_model_i.step(1'b0, 1'b1, 16'h0000, 21'h000000);
    rdc(`DHS_ADDR_IBC, 16'h0006);
    wr(`DHS_ADDR_SPR, 16'h0505);
    push(16'h0005);
    rdc(`DHS_ADDR_IBC, 16'h0018);
    // upper substack chosen through the pointer write
    wr(`DHS_ADDR_SUR, 16'h0101);
    wr(`DHS_ADDR_SVR, 16'hffff);
    wr(`DHS_ADDR_SPR, 16'h3f3f);
    push(16'h0ccc);
    rdc(`DHS_ADDR_SPR, 16'h2020);
    rdc(`DHS_ADDR_IBC, 16'h0019);
    wr(`DHS_ADDR_SPR, 16'h2020);
    pop_chk(16'h0ccc);
    rdc(`DHS_ADDR_IBC, 16'h0007);
    rdc(`DHS_ADDR_SPR, 16'h3f3f);
    // Reserved mode bits read back as zero.
    wr(`DHS_ADDR_SUR, 16'hffff);
    rdc(`DHS_ADDR_SUR, 16'hfbfb);
    // A push while the clock enable is low is not taken.
    ce_i = 1'b0;
    push(16'h0777);
    ce_i = 1'b1;
    rdc(`DHS_ADDR_SPR, 16'h3f3f);
    // Lower 32-word substack with middle start: overflow and fatal both at 15.
    wr(`DHS_ADDR_SUR, 16'h0000);
    wr(`DHS_ADDR_SPR, 16'h0f0f);
    push(16'h0f0f);
    rdc(`DHS_ADDR_IBC, 16'h0019);
    rdc(`DHS_ADDR_SPR, 16'h1010);
    results();
  end
endmodule
